// file: hw/hbha_pkg.sv
`default_nettype none

package hbha_pkg;

    // ****************************************
    // Pin group sizes and timer width
    // ****************************************
    localparam int unsigned BR_LINES    = 6;
    localparam int unsigned ID_W        = 3;
    localparam int unsigned IRQ_LINES   = 3;
    localparam int unsigned FLAG_LINES  = 4;
    localparam int unsigned TIMER_W     = 32;

    // ****************************************
    // Strap values and reset values
    // ****************************************
    localparam logic [2:0] ID_SINGLE    = 3'h0;
    localparam logic [5:0] BR_ONE_HOT_1 = 6'h01;
    localparam logic [5:0] BR_ALL_IDLE  = 6'h3F;

    // ****************************************
    // Timing counts
    // ****************************************
    localparam int unsigned EXPIRE_CYCLES = 4;
    localparam logic [2:0]  EXPIRE_LEN    = 3'(EXPIRE_CYCLES);

    // Host handover sequence
    typedef enum logic [2:0] {
        HB_IDLE    = 3'b001,
        HB_RELEASE = 3'b010,
        HB_GRANT   = 3'b100
    } hbha_host_state_e;

endpackage : hbha_pkg

`default_nettype wire

// file: hw/hbha_sync.sv
`default_nettype none

module hbha_sync #(
    parameter int unsigned WIDTH     = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             i_sys_clk,  // System clock
    input  wire logic             i_arst_n,   // Async reset, active low
    input  wire logic             i_clk_en,   // Clock enable
    input  wire logic [WIDTH-1:0] i_async,    // Pin level
    output logic      [WIDTH-1:0] o_sync      // Synchronised level
);

    logic [WIDTH-1:0] meta_reg;

    // ****************************************
    // Two-stage synchroniser
    // ****************************************
    // First stage feeds only the second stage
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_reg <= INIT;
            o_sync   <= INIT;
        end else if (i_clk_en) begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end

endmodule : hbha_sync

`default_nettype wire

// file: hw/hbha_irq_det.sv
`default_nettype none

module hbha_irq_det #(
    parameter int unsigned WIDTH = 3
) (
    input  wire logic             i_sys_clk,    // System clock
    input  wire logic             i_arst_n,     // Async reset, active low
    input  wire logic             i_clk_en,     // Clock enable
    input  wire logic [WIDTH-1:0] i_irq_n,      // Synced request, active low
    input  wire logic [WIDTH-1:0] i_edge_mode,  // 1 edge, 0 level
    input  wire logic [WIDTH-1:0] i_clear,      // Clear pending pulse
    output logic      [WIDTH-1:0] o_pending     // Pending requests
);

    logic [WIDTH-1:0] prev_reg;
    logic [WIDTH-1:0] set_edge;
    logic [WIDTH-1:0] pending_next;

    // Falling edge or low level per line
    always_comb begin
        set_edge     = prev_reg & ~i_irq_n;
        pending_next = (o_pending & ~i_clear)
                     | (i_edge_mode & set_edge);
        pending_next = (pending_next & i_edge_mode)
                     | (~i_edge_mode & ~i_irq_n);
    end

    // ****************************************
    // Pending state, set wins over clear
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prev_reg  <= '1;
            o_pending <= '0;
        end else if (i_clk_en) begin
            prev_reg  <= i_irq_n;
            o_pending <= pending_next;
        end
    end

endmodule : hbha_irq_det

`default_nettype wire

// file: hw/hbha_arbiter.sv
`default_nettype none

module hbha_arbiter #(
    parameter int unsigned TW = 32
) (
    input  wire logic                       i_sys_clk,     // 40 MHz clock
    input  wire logic                       i_arst_n,      // Async reset
    input  wire logic                       i_clk_en,      // Clock enable
    // Bus float and core access
    input  wire logic                       i_bus_float_request_n, // Pin
    input  wire logic                       i_core_bus_want, // Core wants bus
    input  wire logic                       i_core_ext_req,  // Core access
    output logic                            o_core_stall,    // Halt access
    output logic                            o_ext_bus_oe,    // Drive bus
    output logic                            o_bus_master,    // Own the bus
    // Host handover
    input  wire logic                       i_host_bus_request_n, // Pin
    input  wire logic                       i_host_bus_grant_n,   // Pin in
    output logic                            o_host_bus_grant_n,   // Pin out
    output logic                            o_host_bus_grant_oe,  // Pin oe
    output logic                            o_host_owns_bus, // Host has bus
    // Host wait line
    input  wire logic                       i_chip_select_n,   // Pin
    input  wire logic                       i_host_access_busy, // Need wait
    input  wire logic                       i_wait_line_drive_mode, // 1 act
    output logic                            o_host_wait_line,    // Pin out
    output logic                            o_host_wait_line_oe, // Pin oe
    // Multiprocessor requests
    input  wire logic [hbha_pkg::ID_W-1:0]  i_processor_number_strap, // Pin
    input  wire logic [hbha_pkg::BR_LINES-1:0] i_multiproc_bus_request_n,
    output logic [hbha_pkg::BR_LINES-1:0]   o_multiproc_bus_request_n,
    output logic [hbha_pkg::BR_LINES-1:0]   o_multiproc_bus_request_oe,
    // External transfer request and grant
    input  wire logic                       i_ext_transfer_request_a, // Pin
    input  wire logic                       i_ext_transfer_request_b, // Pin
    input  wire logic                       i_dma_ch7_grant,  // From DMA
    input  wire logic                       i_dma_ch8_grant,  // From DMA
    output logic                            o_dma_ch7_request, // To DMA
    output logic                            o_dma_ch8_request, // To DMA
    output logic                            o_ext_transfer_grant_a, // Pin
    output logic                            o_ext_transfer_grant_a_oe,
    output logic                            o_ext_transfer_grant_b, // Pin
    output logic                            o_ext_transfer_grant_b_oe,
    // Interrupts
    input  wire logic [hbha_pkg::IRQ_LINES-1:0] i_irq_n,       // Pins
    input  wire logic [hbha_pkg::IRQ_LINES-1:0] i_irq_edge_mode, // 1 edge
    input  wire logic [hbha_pkg::IRQ_LINES-1:0] i_irq_clear,   // Clear
    output logic [hbha_pkg::IRQ_LINES-1:0]  o_irq_pending,     // Pending
    // Flags
    input  wire logic [hbha_pkg::FLAG_LINES-1:0] i_flag_pin,   // Pin in
    input  wire logic [hbha_pkg::FLAG_LINES-1:0] i_flag_dir_out, // 1 out
    input  wire logic [hbha_pkg::FLAG_LINES-1:0] i_flag_set_value,
    output logic [hbha_pkg::FLAG_LINES-1:0] o_flag_pin,        // Pin out
    output logic [hbha_pkg::FLAG_LINES-1:0] o_flag_pin_oe,     // Pin oe
    output logic [hbha_pkg::FLAG_LINES-1:0] o_flag_level,      // Condition
    // Timer
    input  wire logic                       i_timer_enable,  // Run timer
    input  wire logic [TW-1:0]              i_timer_period,  // Reload
    output logic [TW-1:0]                   o_timer_count_value, // Count
    output logic                            o_timer_expired_out  // Expiry
);

    import hbha_pkg::*;

    // ****************************************
    // Synchronised pins
    // ****************************************
    logic                  float_n_s;
    logic                  hbr_n_s;
    logic                  hbg_n_s;
    logic                  cs_n_s;
    logic                  dmar_a_s;
    logic                  dmar_b_s;
    logic [ID_W-1:0]       strap_s;
    logic [BR_LINES-1:0]   br_n_s;
    logic [IRQ_LINES-1:0]  irq_n_s;
    logic [FLAG_LINES-1:0] flag_s;

    hbha_sync #(.WIDTH(5), .INIT(5'h1F)) u_sync_ctl (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_clk_en  (i_clk_en),
        .i_async   ({i_bus_float_request_n, i_host_bus_request_n,
                     i_host_bus_grant_n, i_chip_select_n,
                     i_ext_transfer_request_a}),
        .o_sync    ({float_n_s, hbr_n_s, hbg_n_s, cs_n_s, dmar_a_s})
    );

    hbha_sync #(.WIDTH(1), .INIT(1'h1)) u_sync_dmab (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_clk_en  (i_clk_en),
        .i_async   (i_ext_transfer_request_b),
        .o_sync    (dmar_b_s)
    );

    hbha_sync #(.WIDTH(ID_W), .INIT(ID_SINGLE)) u_sync_strap (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_clk_en  (i_clk_en),
        .i_async   (i_processor_number_strap),
        .o_sync    (strap_s)
    );

    hbha_sync #(.WIDTH(BR_LINES), .INIT(BR_ALL_IDLE)) u_sync_br (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_clk_en  (i_clk_en),
        .i_async   (i_multiproc_bus_request_n),
        .o_sync    (br_n_s)
    );

    hbha_sync #(.WIDTH(IRQ_LINES), .INIT('1)) u_sync_irq (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_clk_en  (i_clk_en),
        .i_async   (i_irq_n),
        .o_sync    (irq_n_s)
    );

    hbha_sync #(.WIDTH(FLAG_LINES), .INIT('0)) u_sync_flag (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_clk_en  (i_clk_en),
        .i_async   (i_flag_pin),
        .o_sync    (flag_s)
    );

    // ****************************************
    // Identity strap capture
    // ****************************************
    logic            strap_loaded;
    logic [1:0]      strap_wait_reg;
    logic [ID_W-1:0] strap_reg;

    // Synchroniser holds its reset value for two edges, so wait it out
    assign strap_loaded = &strap_wait_reg;

    // Caught once after reset release, then frozen
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            strap_wait_reg <= 2'h0;
            strap_reg      <= ID_SINGLE;
        end else if (i_clk_en && !strap_loaded) begin
            strap_wait_reg <= strap_wait_reg + 2'h1;
            strap_reg      <= strap_s;
        end
    end

    // ****************************************
    // Multiprocessor arbitration
    // ****************************************
    logic                single_proc;
    logic [BR_LINES-1:0] own_mask;
    logic                lower_active;
    logic                host_wants;
    logic                master_next;
    logic                master_reg;
    hbha_host_state_e    host_state_reg;
    hbha_host_state_e    host_state_next;

    // Own line from strap, priority to lower lines
    always_comb begin
        single_proc  = (strap_reg == ID_SINGLE);
        own_mask     = single_proc ? '0
                     : BR_LINES'(BR_ONE_HOT_1 << (strap_reg - 3'h1));
        lower_active = |(~br_n_s & ~own_mask
                         & (own_mask - BR_ONE_HOT_1));
        host_wants   = !hbr_n_s || !hbg_n_s;
        if (!strap_loaded) begin
            master_next = 1'b0;
        end else if (single_proc) begin
            master_next = 1'b1;
        end else if (master_reg) begin
            master_next = i_core_bus_want
                       || (host_state_reg != HB_IDLE);
        end else begin
            master_next = i_core_bus_want
                       && |(own_mask & ~o_multiproc_bus_request_n)
                       && !lower_active
                       && !host_wants;
        end
    end

    // Own request line only, others left floating
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            master_reg                 <= 1'b0;
            o_bus_master               <= 1'b0;
            o_multiproc_bus_request_n  <= BR_ALL_IDLE;
            o_multiproc_bus_request_oe <= '0;
        end else if (i_clk_en) begin
            master_reg                 <= master_next;
            o_bus_master               <= master_next;
            o_multiproc_bus_request_n  <=
                ~(own_mask & {BR_LINES{i_core_bus_want}});
            o_multiproc_bus_request_oe <= own_mask;
        end
    end

    // ****************************************
    // Host handover sequence
    // ****************************************
    // Float bus first, grant next, hold till release
    always_comb begin
        case (host_state_reg)
            HB_IDLE: begin
                host_state_next = (master_reg && !hbr_n_s)
                                ? HB_RELEASE : HB_IDLE;
            end
            HB_RELEASE: begin
                host_state_next = hbr_n_s ? HB_IDLE : HB_GRANT;
            end
            HB_GRANT: begin
                host_state_next = hbr_n_s ? HB_IDLE : HB_GRANT;
            end
            default: begin
                host_state_next = HB_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            host_state_reg      <= HB_IDLE;
            o_host_bus_grant_n  <= 1'b1;
            o_host_bus_grant_oe <= 1'b0;
            o_host_owns_bus     <= 1'b0;
        end else if (i_clk_en) begin
            host_state_reg      <= host_state_next;
            o_host_bus_grant_n  <= (host_state_next != HB_GRANT);
            o_host_bus_grant_oe <= master_next;
            o_host_owns_bus     <= (host_state_next == HB_GRANT)
                                || (!master_next && !hbg_n_s);
        end
    end

    // ****************************************
    // Bus drive and core stall
    // ****************************************
    logic bus_oe_next;

    assign bus_oe_next = master_next && (host_state_next == HB_IDLE)
                      && float_n_s;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ext_bus_oe <= 1'b0;
            o_core_stall <= 1'b0;
        end else if (i_clk_en) begin
            o_ext_bus_oe <= bus_oe_next;
            o_core_stall <= i_core_ext_req && !bus_oe_next;
        end
    end

    // ****************************************
    // Host wait line
    // ****************************************
    logic wait_drive;

    assign wait_drive = !cs_n_s && !hbr_n_s;

    // Open drain pulls low only, active mode drives both
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_host_wait_line    <= 1'b0;
            o_host_wait_line_oe <= 1'b0;
        end else if (i_clk_en) begin
            if (i_wait_line_drive_mode) begin
                o_host_wait_line    <= !i_host_access_busy;
                o_host_wait_line_oe <= wait_drive;
            end else begin
                o_host_wait_line    <= 1'b0;
                o_host_wait_line_oe <= wait_drive
                                    && i_host_access_busy;
            end
        end
    end

    // ****************************************
    // External transfer request and grant
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_dma_ch7_request         <= 1'b0;
            o_dma_ch8_request         <= 1'b0;
            o_ext_transfer_grant_a    <= 1'b1;
            o_ext_transfer_grant_a_oe <= 1'b0;
            o_ext_transfer_grant_b    <= 1'b1;
            o_ext_transfer_grant_b_oe <= 1'b0;
        end else if (i_clk_en) begin
            o_dma_ch7_request         <= !dmar_a_s;
            o_dma_ch8_request         <= !dmar_b_s;
            o_ext_transfer_grant_a    <= !i_dma_ch7_grant;
            o_ext_transfer_grant_a_oe <= i_dma_ch7_grant;
            o_ext_transfer_grant_b    <= !i_dma_ch8_grant;
            o_ext_transfer_grant_b_oe <= i_dma_ch8_grant;
        end
    end

    // ****************************************
    // Interrupt detection
    // ****************************************
    hbha_irq_det #(.WIDTH(IRQ_LINES)) u_irq (
        .i_sys_clk   (i_sys_clk),
        .i_arst_n    (i_arst_n),
        .i_clk_en    (i_clk_en),
        .i_irq_n     (irq_n_s),
        .i_edge_mode (i_irq_edge_mode),
        .i_clear     (i_irq_clear),
        .o_pending   (o_irq_pending)
    );

    // ****************************************
    // Flag pins
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_flag_pin    <= '0;
            o_flag_pin_oe <= '0;
            o_flag_level  <= '0;
        end else if (i_clk_en) begin
            o_flag_pin    <= i_flag_set_value;
            o_flag_pin_oe <= i_flag_dir_out;
            o_flag_level  <= (flag_s & ~i_flag_dir_out)
                          | (i_flag_set_value & i_flag_dir_out);
        end
    end

    // ****************************************
    // Timer and expiry pulse
    // ****************************************
    logic [2:0] expire_cnt_reg;

    // Reload at zero, expiry pulse lasts four cycles
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_timer_count_value <= '0;
            expire_cnt_reg      <= 3'h0;
            o_timer_expired_out <= 1'b0;
        end else if (i_clk_en) begin
            if (!i_timer_enable) begin
                o_timer_count_value <= i_timer_period;
            end else if (o_timer_count_value == '0) begin
                o_timer_count_value <= i_timer_period;
            end else begin
                o_timer_count_value <= o_timer_count_value - 1'b1;
            end
            if (i_timer_enable
                && o_timer_count_value == TW'(1)) begin
                expire_cnt_reg      <= EXPIRE_LEN;
                o_timer_expired_out <= 1'b1;
            end else if (expire_cnt_reg > 3'h1) begin
                expire_cnt_reg      <= expire_cnt_reg - 3'h1;
                o_timer_expired_out <= 1'b1;
            end else begin
                expire_cnt_reg      <= 3'h0;
                o_timer_expired_out <= 1'b0;
            end
        end
    end

endmodule : hbha_arbiter

`default_nettype wire

// file: test/hbha_props.sv
`default_nettype none

module hbha_props #(
    parameter int unsigned TW = 32
) (
    input wire logic i_sys_clk, // Clock
    input wire logic i_arst_n, // Reset
    input wire logic i_bus_float_request_n, // Float pin
    input wire logic i_host_bus_request_n, // Host request
    input wire logic i_chip_select_n, // Select
    input wire logic i_wait_line_drive_mode, // Wait mode
    input wire logic [hbha_pkg::ID_W-1:0] i_processor_number_strap, // Id
    input wire logic o_core_stall, // Stall
    input wire logic o_ext_bus_oe, // Bus drive
    input wire logic o_bus_master, // Master
    input wire logic o_host_bus_grant_n, // Grant
    input wire logic o_host_bus_grant_oe, // Grant drive
    input wire logic o_host_wait_line, // Wait value
    input wire logic o_host_wait_line_oe, // Wait drive
    input wire logic [hbha_pkg::BR_LINES-1:0] o_multiproc_bus_request_oe, // Oe
    input wire logic [TW-1:0] o_timer_count_value, // Count
    input wire logic o_timer_expired_out // Expiry
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    // Bus and grant ownership
    property p_float; (!i_bus_float_request_n)[*3] |=> !o_ext_bus_oe;
    endproperty
    a_float: assert property (p_float) else $error("bus not floated");
    property p_stall; o_core_stall |-> !o_ext_bus_oe; endproperty
    a_stall: assert property (p_stall) else $error("stall while driving");
    property p_grant_float;
        $fell(o_host_bus_grant_n) |-> !o_ext_bus_oe && !$past(o_ext_bus_oe);
    endproperty
    a_grant_float: assert property (p_grant_float) else $error("early grant");
    property p_grant_hold;
        !o_host_bus_grant_n && !i_host_bus_request_n |=> !o_host_bus_grant_n;
    endproperty
    a_grant_hold: assert property (p_grant_hold) else $error("grant dropped");
    property p_grant_oe; o_host_bus_grant_oe |-> o_bus_master; endproperty
    a_grant_oe: assert property (p_grant_oe) else $error("slave drives grant");
    // Wait line drive
    property p_wait_cs; i_chip_select_n[*5] |-> !o_host_wait_line_oe; endproperty
    a_wait_cs: assert property (p_wait_cs) else $error("wait without select");
    property p_wait_od;
        (!i_wait_line_drive_mode)[*2] ##0 o_host_wait_line_oe |-> !o_host_wait_line;
    endproperty
    a_wait_od: assert property (p_wait_od) else $error("open drain high");
    // Request line and timer
    property p_own_line; o_multiproc_bus_request_oe != 6'h00 |->
        o_multiproc_bus_request_oe == 6'h01 << (i_processor_number_strap - 3'h1);
    endproperty
    a_own_line: assert property (p_own_line) else $error("wrong line");
    property p_expire; $rose(o_timer_expired_out) |-> o_timer_count_value == '0
        ##0 o_timer_expired_out[*4] ##1 !o_timer_expired_out;
    endproperty
    a_expire: assert property (p_expire) else $error("expiry length");
    c_grant: cover property (!o_host_bus_grant_n);
    c_stall: cover property (o_core_stall);
    c_expire: cover property ($rose(o_timer_expired_out));
endmodule : hbha_props

`default_nettype wire

// file: test/hbha_host_model.sv
`default_nettype none

module hbha_host_model (
    input wire logic i_sys_clk, // Clock
    input wire logic i_arst_n, // Reset
    input wire logic i_go, // Start
    input wire logic [2:0] i_hold, // Grant cycles held, minus one
    input wire logic i_grant_n, // Grant wire
    output logic o_req_n, // Bus request
    output logic o_cs_n // Select
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] hold_reg; // Cycles held
    // Host asks, waits for grant, holds the bus, lets go
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_req_n <= 1'b1;
            hold_reg <= 3'h0;
        end else if (o_req_n) begin
            o_req_n <= !i_go;
        end else if (!i_grant_n) begin
            o_req_n <= (hold_reg == i_hold);
            hold_reg <= (hold_reg == i_hold) ? 3'h0 : hold_reg + 3'h1;
        end
    end
    // Select follows the request
    assign o_cs_n = o_req_n;
endmodule : hbha_host_model

`default_nettype wire

// file: test/hbha_arbiter_tb.sv
`default_nettype none

module hbha_arbiter_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import hbha_pkg::*;
    logic i_sys_clk, i_arst_n, i_clk_en, i_bus_float_request_n;
    logic i_core_bus_want, i_core_ext_req, o_core_stall, o_ext_bus_oe;
    logic o_bus_master, i_host_bus_request_n, i_host_bus_grant_n;
    logic o_host_bus_grant_n, o_host_bus_grant_oe, o_host_owns_bus;
    logic i_chip_select_n, i_host_access_busy, i_wait_line_drive_mode;
    logic o_host_wait_line, o_host_wait_line_oe, i_ext_transfer_request_a;
    logic i_ext_transfer_request_b, i_dma_ch7_grant, i_dma_ch8_grant;
    logic o_dma_ch7_request, o_dma_ch8_request, o_ext_transfer_grant_a;
    logic o_ext_transfer_grant_a_oe, o_ext_transfer_grant_b, go;
    logic o_ext_transfer_grant_b_oe, o_timer_expired_out, i_timer_enable;
    logic [ID_W-1:0] i_processor_number_strap, hold;
    logic [IRQ_LINES-1:0] i_irq_n, i_irq_edge_mode, i_irq_clear, o_irq_pending;
    logic [FLAG_LINES-1:0] i_flag_pin, i_flag_dir_out, i_flag_set_value;
    logic [FLAG_LINES-1:0] o_flag_pin, o_flag_pin_oe, o_flag_level, ext;
    logic [BR_LINES-1:0] i_multiproc_bus_request_n, peer_n;
    logic [BR_LINES-1:0] o_multiproc_bus_request_n, o_multiproc_bus_request_oe;
    logic [TIMER_W-1:0] i_timer_period, o_timer_count_value;
    int n_mismatch, cmp_count, cyc, k;
    // Wire levels; floated grant and spare request lines are pulled high
    assign i_host_bus_grant_n = o_host_bus_grant_oe ? o_host_bus_grant_n : 1'b1;
    assign i_multiproc_bus_request_n = (o_multiproc_bus_request_n
        | ~o_multiproc_bus_request_oe) & peer_n;
    assign i_flag_pin = (o_flag_pin & o_flag_pin_oe) | (ext & ~o_flag_pin_oe);
    hbha_arbiter dut (.*);
    hbha_host_model host (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
        .i_go(go), .i_hold(hold), .i_grant_n(i_host_bus_grant_n),
        .o_req_n(i_host_bus_request_n), .o_cs_n(i_chip_select_n));
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    function automatic logic [5:0] br_wire(input logic [2:0] id);
        return ~(6'h01 << (id - 3'h1));
    endfunction : br_wire
    function automatic logic [3:0] flag_lvl(input logic [3:0] d, s, e);
        return (d & s) | (~d & e);
    endfunction : flag_lvl
    task automatic cy(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : cy
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    task automatic complete_run;
        $display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial begin
        {i_arst_n, go, i_core_bus_want, i_core_ext_req, i_host_access_busy} = '0;
        {i_wait_line_drive_mode, i_dma_ch7_grant, i_dma_ch8_grant} = '0;
        {i_irq_edge_mode, i_irq_clear, i_flag_dir_out, i_flag_set_value} = '0;
        {i_timer_enable, ext, i_timer_period} = '0;
        {i_clk_en, i_bus_float_request_n, i_ext_transfer_request_a} = '1;
        {i_ext_transfer_request_b, i_irq_n, peer_n} = '1;
        hold = 3'h4;
        i_processor_number_strap = 3'h2;
        void'($urandom(32'hAA4C3335));
        cy(2);
        i_arst_n <= 1'b1;
        i_core_bus_want <= 1'b1;
        cy(8);
        chk(i_multiproc_bus_request_n, br_wire(i_processor_number_strap));
        chk(o_bus_master, 1'b1);
        for (int r = 0; r < 3; r++) begin
            i_wait_line_drive_mode <= 1'b0;
            i_host_access_busy <= 1'b1;
            hold <= 3'h4 + 3'($urandom_range(3));
            go <= 1'b1;
            cy(1);
            go <= 1'b0;
            for (k = 0; k < 40 && o_host_bus_grant_n !== 1'b0; k++) cy(1);
            chk({o_ext_bus_oe, o_host_owns_bus}, 2'h1);
            chk({o_host_wait_line_oe, o_host_wait_line}, 2'h2);
            i_wait_line_drive_mode <= 1'b1;
            i_host_access_busy <= 1'b0;
            cy(2);
            chk({o_host_wait_line_oe, o_host_wait_line}, 2'h3);
            for (k = 0; k < 40 && i_host_bus_request_n !== 1'b1; k++) cy(1);
            cy(5);
            chk({o_host_bus_grant_n, o_host_wait_line_oe}, 2'h2);
        end
        // Float only as deadlock recovery, core access pending
        i_core_ext_req <= 1'b1;
        i_bus_float_request_n <= 1'b0;
        cy(5);
        chk({o_ext_bus_oe, o_core_stall}, 2'h1);
        i_bus_float_request_n <= 1'b1;
        cy(5);
        chk(o_core_stall, 1'b0);
        for (int r = 0; r < 6; r++) begin
            {i_ext_transfer_request_a, i_ext_transfer_request_b} <= 2'($urandom);
            {i_dma_ch7_grant, i_dma_ch8_grant} <= 2'($urandom);
            {i_flag_dir_out, i_flag_set_value, ext} <= 12'($urandom);
            i_irq_n <= 3'($urandom);
            cy(5);
            chk({o_dma_ch7_request, o_dma_ch8_request},
                {~i_ext_transfer_request_a, ~i_ext_transfer_request_b});
            chk({o_ext_transfer_grant_a_oe, o_ext_transfer_grant_b_oe,
                o_ext_transfer_grant_a, o_ext_transfer_grant_b},
                {i_dma_ch7_grant, i_dma_ch8_grant,
                ~i_dma_ch7_grant, ~i_dma_ch8_grant});
            chk({o_flag_pin_oe, o_flag_pin, o_flag_level}, {i_flag_dir_out,
                i_flag_set_value,
                flag_lvl(i_flag_dir_out, i_flag_set_value, ext)});
            chk(o_irq_pending, i_irq_n ^ 3'h7);
        end
        // Edge mode: a held low level is counted once
        {i_irq_n, i_irq_edge_mode, i_irq_clear} <= '1;
        cy(5);
        {i_irq_n, i_irq_clear} <= '0;
        cy(5);
        chk(o_irq_pending, 3'h7);
        i_irq_clear <= 3'h7;
        cy(1);
        i_irq_clear <= 3'h0;
        cy(3);
        chk(o_irq_pending, 3'h0);
        i_timer_period <= 32'h8 + 32'($urandom_range(15));
        i_timer_enable <= 1'b1;
        for (k = 0; k < 40 && o_timer_expired_out !== 1'b1; k++) cy(1);
        for (k = 0; k < 9 && o_timer_expired_out === 1'b1; k++) cy(1);
        chk(k, 4);
        complete_run();
    end
endmodule : hbha_arbiter_tb

bind hbha_arbiter hbha_props #(.TW(TW)) u_props (.*);

`default_nettype wire
